// *** logic/s0cc_pkg.sv ***
// Purpose: shared constants of the bus 0 cycle controller
// Assumes: byte-wide register port at the documented offsets
// Notes:   all offsets and field positions live here, and reset values except status, go and cycle-done
package s0cc_pkg;

  // register offsets
  localparam logic [7:0] OFS_GO    = 8'h02;
  localparam logic [7:0] OFS_DIV   = 8'h6c;
  localparam logic [7:0] OFS_MISC1 = 8'h6d;
  localparam logic [7:0] OFS_MISC2 = 8'h6e;
  localparam logic [7:0] OFS_INTEN = 8'h70;
  localparam logic [7:0] OFS_CYCLO = 8'h71;
  localparam logic [7:0] OFS_CYCHI = 8'h72;
  localparam logic [7:0] OFS_ISTAT = 8'h73;

  // reset values
  localparam logic [7:0]  RST_DIV   = 8'h02;
  localparam logic [7:0]  RST_MISC1 = 8'h00;
  localparam logic [7:0]  RST_MISC2 = 8'h00;
  localparam logic [7:0]  RST_INTEN = 8'hff;
  localparam logic [15:0] RST_CYC   = 16'h0000;

  // writable masks, reserved bits read zero
  localparam logic [7:0] MSK_MISC1 = 8'h59;
  localparam logic [7:0] MSK_MISC2 = 8'h07;

  // go register fields
  localparam int GO_BIT    = 1;
  localparam int CDONE_BIT = 2;

  // misc control one fields
  localparam int M1_DMA   = 6;
  localparam int M1_CDIE  = 4;
  localparam int M1_DYN   = 3;
  localparam int M1_POST  = 0;

  // misc control two fields
  localparam int M2_NEG   = 2;
  localparam int M2_LAT_H = 1;
  localparam int M2_LAT_L = 0;

  // cycle control word fields
  localparam int CC_LCHK   = 15;
  localparam int CC_TYPE_H = 14;
  localparam int CC_TYPE_L = 13;
  localparam int CC_RLEN_H = 12;
  localparam int CC_RLEN_L = 4;
  localparam int CC_WLEN_H = 3;
  localparam int CC_WLEN_L = 0;

  // status flags driven by the engine
  localparam int ST_FUNDER = 1;
  localparam int ST_FOVER  = 0;

  // cycle types
  localparam logic [1:0] CT_RX   = 2'b00;
  localparam logic [1:0] CT_TX   = 2'b01;
  localparam logic [1:0] CT_TXRX = 2'b10;

endpackage : s0cc_pkg

// *** logic/s0cc_clkdiv.sv ***
// Purpose: bus clock edge ticks from the divider value
// Assumes: ref_clk stands in for the 33 MHz base clock
// Notes:   one tick per half period of the bus clock
module s0cc_clkdiv #(
  parameter int DW = 8
) (
  // clock and reset
  input  wire logic          ref_clk,
  input  wire logic          reset,
  // control
  input  wire logic          run,
  input  wire logic [DW-1:0] div,
  // edge tick
  output logic               tick
);

  logic [DW-1:0] cnt_r;
  logic [DW-1:0] cnt_nxt;
  logic [DW-1:0] half;
  logic          tick_nxt;
  logic          tick_r;

  // half period is n
  // n of zero cannot be faster than one base cycle per half
  always_comb begin
    half     = (div == '0) ? DW'(1) : div;
    cnt_nxt  = cnt_r;
    tick_nxt = 1'b0;
    if (!run) begin
      cnt_nxt = '0;
    end else if (cnt_r == half - DW'(1)) begin
      cnt_nxt  = '0;
      tick_nxt = 1'b1;
    end else begin
      cnt_nxt = cnt_r + DW'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt & run;
    end
  end

  assign tick = tick_r & run;

endmodule : s0cc_clkdiv

// *** logic/s0cc_top.sv ***
// Purpose: bus 0 serial master cycle control with its registers
// Assumes: byte register port at documented offsets, mode 0 framing
// Notes:   one byte each way per stream handshake
//
// Notes on behaviour
// - mode bit picks programmed-io or dma
// - cycle-done interrupt only when enabled
// - dynamic clock stops controller when idle
// - posted write acknowledges before shifting ends
// - negative-edge bit samples on falling edge
// - latency field bypass or delay-line 1..3
// - buffer half interrupt enables reset set
// - underrun and overrun enables reset set
// - no length check: run until go clears
// - length check: exact read/write counts
// - cycle type: rx, tx, tx-then-rx, reserved
// - receive length field plus one, 512
// - transmit length field plus one, 16
// - bus clock divided by twice n
// - status flags set, cleared writing one
module s0cc_top #(
  parameter int RLW = 9,
  parameter int WLW = 4
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // transmit stream
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  output logic            wr_done,
  // receive stream
  output logic      [7:0] rx_data,
  output logic            rx_valid,
  input  wire logic       rx_ack,
  // dma events, status bits 7..2
  input  wire logic [5:0] dma_evt,
  // controller state
  output logic            dma_mode,
  output logic            core_clk_en,
  output logic            irq,
  // serial pins
  output logic            sck,
  output logic            cs_n,
  output logic            mosi,
  input  wire logic       miso
);

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_TX   = 2'b01,
    S_RX   = 2'b10,
    S_DONE = 2'b11
  } s0cc_state_t;

  // register state
  logic [7:0]  div_r,   div_nxt;
  logic [7:0]  misc1_r, misc1_nxt;
  logic [7:0]  misc2_r, misc2_nxt;
  logic [7:0]  inten_r, inten_nxt;
  logic [15:0] cyc_r,   cyc_nxt;
  logic [7:0]  istat_r, istat_nxt;
  logic        go_r,    go_nxt;
  logic        cdone_r, cdone_nxt;
  logic [7:0]  rdata_r, rdata_nxt;
  logic        irq_r,   irq_nxt;
  logic        cken_r,  cken_nxt;

  // engine state
  s0cc_state_t st_r, st_nxt;
  logic [2:0]     bit_r,   bit_nxt;
  logic [RLW-1:0] cnt_r,   cnt_nxt;
  logic [7:0]     txsh_r,  txsh_nxt;
  logic [7:0]     rxsh_r,  rxsh_nxt;
  logic           have_r,  have_nxt;
  logic           sck_r,   sck_nxt;
  logic           csn_r,   csn_nxt;
  logic           mosi_r,  mosi_nxt;
  logic [7:0]     rxd_r,   rxd_nxt;
  logic           rxv_r,   rxv_nxt;
  logic           txr_r,   txr_nxt;
  logic           wdn_r,   wdn_nxt;
  logic [2:0]     mdly_r;

  // engine to register events
  logic ev_under;
  logic ev_over;
  logic ev_done;
  logic tick;
  logic samp;
  logic samp_now;
  logic last;
  logic lchk;
  logic [1:0] ctype;
  logic [RLW-1:0] rlen;
  logic [RLW-1:0] wlen;
  logic [7:0] rx_full;

  assign lchk  = cyc_r[s0cc_pkg::CC_LCHK];
  assign ctype = cyc_r[s0cc_pkg::CC_TYPE_H:s0cc_pkg::CC_TYPE_L];
  assign rlen  = cyc_r[s0cc_pkg::CC_RLEN_H:s0cc_pkg::CC_RLEN_L];
  assign wlen  = RLW'(cyc_r[s0cc_pkg::CC_WLEN_H:s0cc_pkg::CC_WLEN_L]);

  s0cc_clkdiv #(
    .DW (8)
  ) u_div (
    .ref_clk (ref_clk),
    .reset   (reset),
    .run     (have_r),
    .div     (div_r),
    .tick    (tick)
  );

  always_comb begin
    unique case (misc2_r[s0cc_pkg::M2_LAT_H:s0cc_pkg::M2_LAT_L])
      2'b00: samp = miso;
      2'b01: samp = mdly_r[0];
      2'b10: samp = mdly_r[1];
      2'b11: samp = mdly_r[2];
    endcase
  end

  assign samp_now = tick & (sck_r == misc2_r[s0cc_pkg::M2_NEG]);
  assign rx_full  = samp_now ? {rxsh_r[6:0], samp} : rxsh_r;

  always_comb begin
    if (!lchk) begin
      last = !go_r;
    end else if (st_r == S_TX) begin
      last = (cnt_r == wlen);
    end else begin
      last = (cnt_r == rlen);
    end
  end

  always_comb begin
    st_nxt   = st_r;
    bit_nxt  = bit_r;
    cnt_nxt  = cnt_r;
    txsh_nxt = txsh_r;
    rxsh_nxt = rx_full;
    have_nxt = have_r;
    sck_nxt  = sck_r;
    csn_nxt  = csn_r;
    mosi_nxt = mosi_r;
    rxd_nxt  = rxd_r;
    rxv_nxt  = rxv_r & ~rx_ack;
    txr_nxt  = 1'b0;
    wdn_nxt  = 1'b0;
    ev_under = 1'b0;
    ev_over  = 1'b0;
    ev_done  = 1'b0;
    unique case (st_r)
      S_IDLE: begin
        bit_nxt = '0;
        cnt_nxt = '0;
        // cycle type decode, reserved ends at once
        if (go_r) begin
          csn_nxt = 1'b0;
          unique case (ctype)
            s0cc_pkg::CT_RX:   st_nxt = S_RX;
            s0cc_pkg::CT_TX:   st_nxt = S_TX;
            s0cc_pkg::CT_TXRX: st_nxt = S_TX;
            default:           st_nxt = S_DONE;
          endcase
        end
      end
      S_TX, S_RX: begin
        if (!have_r) begin
          if (st_r == S_RX) begin
            have_nxt = 1'b1;
          end else if (tx_valid) begin
            have_nxt = 1'b1;
            txsh_nxt = tx_data;
            mosi_nxt = tx_data[7];
            txr_nxt  = 1'b1;
            wdn_nxt  = misc1_r[s0cc_pkg::M1_POST] & ~misc1_r[s0cc_pkg::M1_DMA];
          end else if (!go_r && !lchk) begin
            st_nxt = S_DONE;
          end else begin
            // stalls rather than sending filler
            ev_under = 1'b1;
          end
        end else if (tick) begin
          sck_nxt = ~sck_r;
          if (sck_r) begin
            bit_nxt = bit_r + 3'h1;
            if (st_r == S_TX) begin
              txsh_nxt = {txsh_r[6:0], 1'b0};
              mosi_nxt = txsh_r[6];
            end
            if (bit_r == 3'h7) begin
              have_nxt = 1'b0;
              cnt_nxt  = cnt_r + RLW'(1);
              if (st_r == S_TX) begin
                wdn_nxt = ~misc1_r[s0cc_pkg::M1_POST] & ~misc1_r[s0cc_pkg::M1_DMA];
              end else begin
                // overrun when previous byte not taken
                ev_over = rxv_r & ~rx_ack;
                rxd_nxt = rx_full;
                rxv_nxt = 1'b1;
              end
              if (last) begin
                cnt_nxt = '0;
                if (st_r == S_TX && ctype == s0cc_pkg::CT_TXRX) begin
                  st_nxt = S_RX;
                end else begin
                  st_nxt = S_DONE;
                end
              end
            end
          end
        end
      end
      S_DONE: begin
        csn_nxt  = 1'b1;
        sck_nxt  = 1'b0;
        mosi_nxt = 1'b0;
        have_nxt = 1'b0;
        ev_done  = 1'b1;
        st_nxt   = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_r   <= S_IDLE;
      bit_r  <= '0;
      cnt_r  <= '0;
      txsh_r <= '0;
      rxsh_r <= '0;
      have_r <= 1'b0;
      sck_r  <= 1'b0;
      csn_r  <= 1'b1;
      mosi_r <= 1'b0;
      rxd_r  <= '0;
      rxv_r  <= 1'b0;
      txr_r  <= 1'b0;
      wdn_r  <= 1'b0;
      mdly_r <= '0;
    end else begin
      st_r   <= st_nxt;
      bit_r  <= bit_nxt;
      cnt_r  <= cnt_nxt;
      txsh_r <= txsh_nxt;
      rxsh_r <= rxsh_nxt;
      have_r <= have_nxt;
      sck_r  <= sck_nxt;
      csn_r  <= csn_nxt;
      mosi_r <= mosi_nxt;
      rxd_r  <= rxd_nxt;
      rxv_r  <= rxv_nxt;
      txr_r  <= txr_nxt;
      wdn_r  <= wdn_nxt;
      mdly_r <= {mdly_r[1:0], miso};
    end
  end

  // register file
  always_comb begin
    div_nxt   = div_r;
    misc1_nxt = misc1_r;
    misc2_nxt = misc2_r;
    inten_nxt = inten_r;
    cyc_nxt   = cyc_r;
    go_nxt    = go_r;
    cdone_nxt = cdone_r;
    istat_nxt = istat_r;
    rdata_nxt = rdata_r;
    if (reg_wr) begin
      unique case (reg_addr)
        s0cc_pkg::OFS_DIV:   div_nxt   = reg_wdata;
        s0cc_pkg::OFS_MISC1: misc1_nxt = reg_wdata & s0cc_pkg::MSK_MISC1;
        s0cc_pkg::OFS_MISC2: misc2_nxt = reg_wdata & s0cc_pkg::MSK_MISC2;
        s0cc_pkg::OFS_INTEN: inten_nxt = reg_wdata;
        s0cc_pkg::OFS_CYCLO: cyc_nxt[7:0]  = reg_wdata;
        s0cc_pkg::OFS_CYCHI: cyc_nxt[15:8] = reg_wdata;
        s0cc_pkg::OFS_ISTAT: istat_nxt = istat_r & ~reg_wdata;
        s0cc_pkg::OFS_GO: begin
          go_nxt    = reg_wdata[s0cc_pkg::GO_BIT];
          cdone_nxt = cdone_r & ~reg_wdata[s0cc_pkg::CDONE_BIT];
        end
        default: ;
      endcase
    end
    // go drops when a checked cycle ends
    if (ev_done && lchk) begin
      go_nxt = 1'b0;
    end
    // set wins over a same-cycle clear
    istat_nxt = istat_nxt | {dma_evt, ev_under, ev_over};
    cdone_nxt = cdone_nxt | ev_done;
    if (reg_rd) begin
      unique case (reg_addr)
        s0cc_pkg::OFS_DIV:   rdata_nxt = div_r;
        s0cc_pkg::OFS_MISC1: rdata_nxt = misc1_r;
        s0cc_pkg::OFS_MISC2: rdata_nxt = misc2_r;
        s0cc_pkg::OFS_INTEN: rdata_nxt = inten_r;
        s0cc_pkg::OFS_CYCLO: rdata_nxt = cyc_r[7:0];
        s0cc_pkg::OFS_CYCHI: rdata_nxt = cyc_r[15:8];
        s0cc_pkg::OFS_ISTAT: rdata_nxt = istat_r;
        s0cc_pkg::OFS_GO:    rdata_nxt = {5'h00, cdone_r, go_r, 1'b0};
        default:             rdata_nxt = 8'h00;
      endcase
    end
  end

  // controller clock only while work is pending when the dynamic bit is set, always on when it is clear
  always_comb begin
    irq_nxt  = (|(istat_r & inten_r)) | (cdone_r & misc1_r[s0cc_pkg::M1_CDIE]);
    cken_nxt = ~misc1_r[s0cc_pkg::M1_DYN] | (st_r != S_IDLE) | go_r
             | reg_wr | reg_rd | tx_valid;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      div_r   <= s0cc_pkg::RST_DIV;
      misc1_r <= s0cc_pkg::RST_MISC1;
      misc2_r <= s0cc_pkg::RST_MISC2;
      inten_r <= s0cc_pkg::RST_INTEN;
      cyc_r   <= s0cc_pkg::RST_CYC;
      istat_r <= 8'h00;
      go_r    <= 1'b0;
      cdone_r <= 1'b0;
      rdata_r <= 8'h00;
      irq_r   <= 1'b0;
      cken_r  <= 1'b1;
    end else begin
      div_r   <= div_nxt;
      misc1_r <= misc1_nxt;
      misc2_r <= misc2_nxt;
      inten_r <= inten_nxt;
      cyc_r   <= cyc_nxt;
      istat_r <= istat_nxt;
      go_r    <= go_nxt;
      cdone_r <= cdone_nxt;
      rdata_r <= rdata_nxt;
      irq_r   <= irq_nxt;
      cken_r  <= cken_nxt;
    end
  end

  // mode bit steers acknowledge path and dma side
  assign dma_mode    = misc1_r[s0cc_pkg::M1_DMA];
  assign reg_rdata   = rdata_r;
  assign tx_ready    = txr_r;
  assign wr_done     = wdn_r;
  assign rx_data     = rxd_r;
  assign rx_valid    = rxv_r;
  assign core_clk_en = cken_r;
  assign irq         = irq_r;
  assign sck         = sck_r;
  assign cs_n        = csn_r;
  assign mosi        = mosi_r;

endmodule : s0cc_top

// *** testbench/s0cc_asserts.sv ***
// Purpose: port checks of the bus 0 cycle controller
// Assumes: sees only the top module ports
// Notes:   shadows misc1 and enable writes, the rest is port timing
module s0cc_asserts (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       reset,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // streams
  input wire logic       tx_valid,
  input wire logic       tx_ready,
  input wire logic       wr_done,
  input wire logic       rx_valid,
  input wire logic       rx_ack,
  // state and pins
  input wire logic       dma_mode,
  input wire logic       core_clk_en,
  input wire logic       sck,
  input wire logic       cs_n,
  input wire logic       mosi
);
  logic wm1;
  logic dyn_r;
  logic dyn_nxt;
  logic ienw_r;
  logic ienw_nxt;
  assign wm1 = reg_wr && reg_addr == s0cc_pkg::OFS_MISC1;
  always_comb begin
    dyn_nxt  = wm1 ? reg_wdata[s0cc_pkg::M1_DYN] : dyn_r;
    ienw_nxt = ienw_r || (reg_wr && reg_addr == s0cc_pkg::OFS_INTEN);
  end
  // flops only, reset clears shadows
  always_ff @(posedge ref_clk) begin
    dyn_r  <= reset ? 1'b0 : dyn_nxt;
    ienw_r <= reset ? 1'b0 : ienw_nxt;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_inten;
    !ienw_r && reg_rd && reg_addr == s0cc_pkg::OFS_INTEN |=> reg_rdata == 8'hff;
  endproperty
  a_inten: assert property (p_inten) else $error("enables not ff after reset");
  property p_m1_rsvd;
    reg_rd && reg_addr == s0cc_pkg::OFS_MISC1 |=> (reg_rdata & ~s0cc_pkg::MSK_MISC1) == 8'h00;
  endproperty
  a_m1_rsvd: assert property (p_m1_rsvd) else $error("misc1 reserved bits set");
  property p_m2_rsvd;
    reg_rd && reg_addr == s0cc_pkg::OFS_MISC2 |=> (reg_rdata & ~s0cc_pkg::MSK_MISC2) == 8'h00;
  endproperty
  a_m2_rsvd: assert property (p_m2_rsvd) else $error("misc2 reserved bits set");
  property p_dma_src;
    $changed(dma_mode) |-> $past(wm1) || $past(wm1, 2);
  endproperty
  a_dma_src: assert property (p_dma_src) else $error("mode moved without misc1 write");
  property p_clk_free;
    !dyn_r && !$past(dyn_r) && !$past(dyn_r, 2) |-> core_clk_en;
  endproperty
  a_clk_free: assert property (p_clk_free) else $error("clock stopped in free mode");
  property p_sck_idle;
    cs_n && $past(cs_n) |-> !sck;
  endproperty
  a_sck_idle: assert property (p_sck_idle) else $error("sck moves while deselected");
  property p_mosi_fall;
    !cs_n && $changed(mosi) |-> !sck;
  endproperty
  a_mosi_fall: assert property (p_mosi_fall) else $error("mosi moved with sck high");
  property p_tx_cause;
    tx_ready |-> $past(tx_valid);
  endproperty
  a_tx_cause: assert property (p_tx_cause) else $error("byte taken without offer");
  property p_tx_pulse;
    tx_ready |=> !tx_ready;
  endproperty
  a_tx_pulse: assert property (p_tx_pulse) else $error("tx_ready longer than a cycle");
  property p_rx_hold;
    rx_valid && !rx_ack |=> rx_valid;
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx byte dropped before ack");
  property p_no_wrdone;
    dma_mode && $past(dma_mode) |-> !wr_done;
  endproperty
  a_no_wrdone: assert property (p_no_wrdone) else $error("write done in dma mode");
  c_tx: cover property (tx_ready && wr_done);
  c_rx: cover property (rx_valid && rx_ack);
  c_end: cover property ($rose(cs_n));
endmodule : s0cc_asserts

bind s0cc_top s0cc_asserts u_s0cc_asserts (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .wr_done(wr_done), .rx_valid(rx_valid), .rx_ack(rx_ack), .dma_mode(dma_mode),
  .core_clk_en(core_clk_en), .sck(sck), .cs_n(cs_n), .mosi(mosi));

// *** testbench/s0cc_flash_model.sv ***
// Purpose: serial peripheral on the bus 0 pins
// Assumes: mode 0, msb first, one ref cycle of output delay
// Notes:   released miso toggles each cycle, there is no pull resistor
module s0cc_flash_model (
  // clock
  input  wire logic       ref_clk,
  // serial pins
  input  wire logic       sck,
  input  wire logic       cs_n,
  input  wire logic       mosi,
  output logic            miso,
  // reply and capture
  input  wire logic [7:0] reply,
  output logic      [7:0] got,
  output int              got_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       sck_q = 1'b0;
  logic       cs_q  = 1'b1;
  logic [2:0] idx   = 3'h7;
  logic [2:0] nb    = 3'h0;
  logic [7:0] sh    = 8'h00;
  initial begin
    miso  = 1'b0;
    got   = 8'h00;
    got_n = 0;
  end
  always @(posedge ref_clk) begin
    sck_q <= sck;
    cs_q  <= cs_n;
    if (cs_n) begin
      miso <= ~miso;
      idx  <= 3'h7;
      nb   <= 3'h0;
    end else begin
      // next bit after select or a falling edge
      if (cs_q || (sck_q && !sck)) begin
        miso <= reply[idx];
        idx  <= idx - 3'h1;
      end
      if (!sck_q && sck) begin
        sh <= {sh[6:0], mosi};
        nb <= nb + 3'h1;
        if (nb == 3'h7) begin
          got   <= {sh[6:0], mosi};
          got_n <= got_n + 1;
        end
      end
    end
  end
endmodule : s0cc_flash_model

// *** testbench/spi_bus0_cycle_control_bench.sv ***
// Purpose: self-checking bench of the bus 0 cycle controller
// Assumes: inputs change at the falling edge
// Notes:   divider 6 keeps the model bit timing clear of delay-line taps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; $display("Error %0t: %h not %h", $time, a, b); end end
module spi_bus0_cycle_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct { logic [15:0] cw; logic [7:0] m2; int nt; int nr; } s0cc_row_t;
  logic       ref_clk = 1'b0;
  logic       reset   = 1'b1;
  logic [7:0] reg_addr  = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr  = 1'b0;
  logic       reg_rd  = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic       tx_valid = 1'b0;
  logic       rx_ack  = 1'b0;
  logic [5:0] dma_evt = 6'h00;
  logic [7:0] reg_rdata, rx_data, got, rd_v, lrx, ltx;
  logic       tx_ready, wr_done, rx_valid, dma_mode, core_clk_en, irq, sck, cs_n, mosi, miso;
  int         n_mismatch, comparisons, cyc, ntx, nwd, nwu, nrx, got_n, g0;
  // tx-then-rx row c000 keeps length check set
  s0cc_row_t  rows [8] = '{'{16'ha000, 8'h00, 1, 0}, '{16'ha00f, 8'h00, 16, 0}, '{16'h8010, 8'h00, 0, 2},
    '{16'h8010, 8'h01, 0, 2}, '{16'h8010, 8'h02, 0, 2}, '{16'h8010, 8'h07, 0, 2},
    '{16'hc000, 8'h03, 1, 1}, '{16'he000, 8'h00, 0, 0}};
  logic [7:0] ra [6] = '{8'h6c, 8'h6d, 8'h6e, 8'h70, 8'h71, 8'h72};
  logic [7:0] rv [6] = '{8'h02, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00};
  logic [7:0] wv [6] = '{8'h06, 8'h59, 8'h07, 8'hff, 8'hff, 8'hff};
  s0cc_top u_s0cc_top (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .wr_done(wr_done), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ack(rx_ack),
    .dma_evt(dma_evt), .dma_mode(dma_mode), .core_clk_en(core_clk_en), .irq(irq), .sck(sck),
    .cs_n(cs_n), .mosi(mosi), .miso(miso));
  s0cc_flash_model u_s0cc_flash_model (.ref_clk(ref_clk), .sck(sck), .cs_n(cs_n), .mosi(mosi),
    .miso(miso), .reply(8'ha5), .got(got), .got_n(got_n));
  initial forever #5 ref_clk = ~ref_clk;
  task automatic tally_and_finish();
    if (n_mismatch == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge ref_clk);
    reg_wr    = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge ref_clk);
    reg_rd   = 1'b0;
    rd_v     = reg_rdata;
  endtask : rd
  task automatic wait_irq(input int n);
    for (int k = 0; k < n && irq !== 1'b1; k++)
      @(negedge ref_clk);
  endtask : wait_irq
  task automatic evt(input logic [5:0] e);
    @(negedge ref_clk);
    dma_evt = e;
    @(negedge ref_clk);
    dma_evt = 6'h00;
    repeat (3) @(negedge ref_clk);
  endtask : evt
  // hang guard, whole run is a few thousand cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  // stream side: count takes, ack each received byte once
  always @(negedge ref_clk) begin
    if (tx_ready === 1'b1) begin
      ntx++;
      ltx = tx_data;
      tx_data = tx_data + 8'h35;
    end
    if (wr_done === 1'b1 && tx_ready === 1'b1)
      nwd++;
    if (wr_done === 1'b1 && tx_ready !== 1'b1)
      nwu++;
    if (rx_valid === 1'b1 && rx_ack === 1'b0) begin
      nrx++;
      lrx = rx_data;
    end
    rx_ack = rx_valid === 1'b1 && rx_ack === 1'b0;
  end
  initial begin
    repeat (10) @(negedge ref_clk);
    reset    = 1'b0;
    tx_valid = 1'b1;
    wr(s0cc_pkg::OFS_INTEN, 8'h00);
    wr(s0cc_pkg::OFS_MISC1, 8'h11);
    wr(s0cc_pkg::OFS_DIV, 8'h06);
    foreach (rows[i]) begin
      ntx = 0;
      nwd = 0;
      nrx = 0;
      g0  = got_n;
      wr(s0cc_pkg::OFS_MISC2, rows[i].m2);
      wr(s0cc_pkg::OFS_CYCLO, rows[i].cw[7:0]);
      wr(s0cc_pkg::OFS_CYCHI, rows[i].cw[15:8]);
      wr(s0cc_pkg::OFS_GO, 8'h02);
      wait_irq(5000);
      `CHK(irq, 1'b1)
      rd(s0cc_pkg::OFS_GO);
      `CHK(rd_v, 8'h04)
      `CHK(ntx, rows[i].nt)
      `CHK(nwd, rows[i].nt)
      `CHK(nrx, rows[i].nr)
      `CHK(got_n - g0, rows[i].nt + rows[i].nr)
      if (rows[i].nt > 0 && rows[i].nr == 0)
        `CHK(got, ltx)
      if (rows[i].nr > 0)
        `CHK(lrx, 8'ha5)
      wr(s0cc_pkg::OFS_GO, 8'h04);
      @(negedge ref_clk);
      `CHK(irq, 1'b0)
    end
    // unposted from here on, done follows each shift out
    wr(s0cc_pkg::OFS_MISC1, 8'h00);
    wr(s0cc_pkg::OFS_INTEN, 8'h04);
    evt(6'h01);
    `CHK(irq, 1'b1)
    wr(s0cc_pkg::OFS_ISTAT, 8'h04);
    @(negedge ref_clk);
    `CHK(irq, 1'b0)
    wr(s0cc_pkg::OFS_INTEN, 8'h00);
    evt(6'h20);
    `CHK(irq, 1'b0)
    rd(s0cc_pkg::OFS_ISTAT);
    `CHK(rd_v[7], 1'b1)
    wr(s0cc_pkg::OFS_ISTAT, 8'hff);
    ntx = 0;
    nwu = 0;
    wr(s0cc_pkg::OFS_CYCLO, 8'h00);
    wr(s0cc_pkg::OFS_CYCHI, 8'h20);
    wr(s0cc_pkg::OFS_GO, 8'h02);
    for (int k = 0; k < 3000 && ntx < 3; k++)
      @(negedge ref_clk);
    wr(s0cc_pkg::OFS_GO, 8'h00);
    for (int k = 0; k < 1000 && cs_n !== 1'b1; k++)
      @(negedge ref_clk);
    `CHK(cs_n, 1'b1)
    `CHK(ntx >= 3, 1'b1)
    `CHK(nwu, ntx)
    // a standing offer counts as a request and keeps the clock on
    tx_valid = 1'b0;
    wr(s0cc_pkg::OFS_MISC1, 8'h48);
    for (int k = 0; k < 20 && core_clk_en !== 1'b0; k++)
      @(negedge ref_clk);
    `CHK(dma_mode, 1'b1)
    `CHK(core_clk_en, 1'b0)
    wr(s0cc_pkg::OFS_MISC1, 8'h00);
    repeat (3) @(negedge ref_clk);
    `CHK(dma_mode, 1'b0)
    `CHK(core_clk_en, 1'b1)
    foreach (ra[i]) begin
      wr(ra[i], 8'hff);
      rd(ra[i]);
      `CHK(rd_v, ra[i] == 8'h6c ? 8'hff : wv[i])
    end
    wr(8'h6f, 8'h55);
    rd(8'h6f);
    `CHK(rd_v, 8'h00)
    @(negedge ref_clk);
    reset = 1'b1;
    repeat (2) @(negedge ref_clk);
    reset = 1'b0;
    foreach (ra[i]) begin
      rd(ra[i]);
      `CHK(rd_v, rv[i])
    end
    tally_and_finish();
  end
endmodule : spi_bus0_cycle_control_bench
